// ==== rtl/seq_pkg.sv ====
package seq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_BSIZE = 8'h04;
  localparam logic [7:0] OFF_NBLK = 8'h08;
  localparam logic [7:0] OFF_BINC = 8'h0C;
  localparam logic [7:0] OFF_AINC = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;
  localparam logic [7:0] OFF_SDLY = 8'h18;
  localparam logic [7:0] OFF_LAUNCH = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_GADDR = 8'h24;
  localparam logic [7:0] OFF_MAP0 = 8'h40;
  // mode register fields
  localparam int MODE_W = 6;
  localparam int RUN_LO_POS = 0;
  localparam int RUN_HI_POS = 1;
  localparam int DUAL_POS = 2;
  localparam int SKEW_POS = 3;
  localparam int SKEW_W = 3;
  localparam int SDLY_W = 5;
  localparam int MAP_W = 6;
  localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
  localparam logic [SDLY_W-1:0] SDLY_RST = 5'h00;
  // status register fields
  localparam int ST_RUN_POS = 0;
  localparam int ST_HOLD_POS = 1;
  localparam int ST_BUSY_POS = 2;
  // width of the generator and of one half
  localparam int AW = 24;
  localparam int HW = 12;
  localparam int MAP_LAST = 23;
  // busy window after reset release
  localparam int BUSY_CLKS = 25;
  // sequencer states, gray along idle-run-hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b11
  } seq_state_e;
  // per-address marker flags travelling with the address
  typedef struct packed {
    logic first;
    logic blk_end;
    logic seq_end;
  } seq_flags_s;
endpackage

// ==== rtl/addr_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module addr_sequencer
  import seq_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // sequencer pins
  input wire logic ext_launch_in_n,
  input wire logic block_hold,
  output logic [AW-1:0] addr_out,
  output logic block_end_n,
  output logic seq_done_n,
  output logic first_addr_valid_n,
  output logic sync_launch_out_n,
  output logic busy_n
);

  // bus phase capture
  logic wsel_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata_mux;
  // software registers
  logic [AW-1:0] start_q, bsize_q, nblk_q, binc_q, ainc_q;
  logic [MODE_W-1:0] mode_q;
  logic [SDLY_W-1:0] sdly_q;
  logic [MAP_W-1:0] map_q [AW];
  // shadow copies taken at launch
  logic [AW-1:0] s_bsize_q, s_nblk_q, s_binc_q, s_ainc_q;
  // sequencer
  seq_state_e state_q, state_d;
  logic [AW-1:0] gen_q, gen_d, bstart_q, bstart_d, acnt_q, acnt_d, bcnt_q, bcnt_d;
  logic first_q, first_d, pend_q, pend_d;
  // start circuitry
  logic ext_prev_q;
  logic [SDLY_W-1:0] dcnt_q;
  logic [4:0] busy_cnt_q;
  // output stage
  logic [AW-1:HW] hi_q;
  seq_flags_s flg_q;
  logic [HW:0] skew_q [8];
  logic sync_q;

  // bus decode
  wire addr_ph = hsel & hready & htrans[1];
  wire busy = (busy_cnt_q != 5'h00) & (busy_cnt_q <= 5'(BUSY_CLKS));
  wire wr_en = wsel_q & ~busy;
  wire wr_launch = wr_en & (waddr_q == OFF_LAUNCH);
  wire map_hit = (waddr_q >= OFF_MAP0) & (waddr_q < OFF_MAP0 + 8'(4 * AW));
  wire [4:0] map_idx = 5'((waddr_q - OFF_MAP0) >> 2);
  wire [7:0] raddr = {haddr[7:2], 2'b00};
  wire rmap_hit = (raddr >= OFF_MAP0) & (raddr < OFF_MAP0 + 8'(4 * AW));
  wire [4:0] rmap_idx = 5'((raddr - OFF_MAP0) >> 2);

  // mode decode
  // run mode decode
  wire cont = mode_q[RUN_HI_POS];
  wire restart = ~mode_q[RUN_HI_POS] & mode_q[RUN_LO_POS];
  wire dual = mode_q[DUAL_POS];
  wire [SKEW_W-1:0] skew = mode_q[SKEW_POS +: SKEW_W];

  // block and sequence end at the current address
  // block end compare
  wire blk_end = (state_q == ST_RUN) & (acnt_q == s_bsize_q);
  wire seq_end = blk_end & (bcnt_q == s_nblk_q) & ~cont;

  // launch requests
  wire ext_req = ~ext_prev_q & ext_launch_in_n;
  wire auto_req = (seq_end & restart & ~block_hold) | ((state_q == ST_HOLD) & pend_q & ~block_hold);
  wire req = wr_launch | ext_req | auto_req;
  wire go = (req & (sdly_q == 5'h00)) | (dcnt_q == 5'h01);

  // adder with optional carry cut
  function automatic logic [AW-1:0] add24(input logic [AW-1:0] a, input logic [AW-1:0] b, input logic dl);
    logic [HW:0] lo;
    logic [HW-1:0] hi;
    lo = {1'b0, a[HW-1:0]} + {1'b0, b[HW-1:0]};
    hi = a[AW-1:HW] + b[AW-1:HW] + {11'h000, lo[HW] & ~dl};
    add24 = {hi, lo[HW-1:0]};
  endfunction

  // adder operand selection
  wire new_blk = (state_q == ST_HOLD) | blk_end;
  wire [AW-1:0] adder_sel_a = new_blk ? bstart_q : gen_q;
  wire [AW-1:0] adder_sel_b = new_blk ? s_binc_q : s_ainc_q;
  wire [AW-1:0] sum = add24(adder_sel_a, adder_sel_b, dual);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    gen_d = gen_q;
    bstart_d = bstart_q;
    acnt_d = acnt_q;
    bcnt_d = bcnt_q;
    first_d = 1'b0;
    pend_d = pend_q;
    if (go) begin
      gen_d = add24(start_q, 24'h000000, dual);
      bstart_d = add24(start_q, 24'h000000, dual);
      acnt_d = 24'h000001;
      bcnt_d = 24'h000001;
      first_d = 1'b1;
      pend_d = 1'b0;
      state_d = ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (seq_end) begin
            state_d = (restart & block_hold) ? ST_HOLD : ST_IDLE;
            pend_d = restart & block_hold;
          end else if (blk_end & block_hold) begin
            state_d = ST_HOLD;
          end else if (blk_end) begin
            gen_d = sum;
            bstart_d = sum;
            acnt_d = 24'h000001;
            bcnt_d = bcnt_q + 24'h000001;
          end else begin
            gen_d = sum;
            acnt_d = acnt_q + 24'h000001;
          end
        end
        ST_HOLD: begin
          if (~block_hold & ~pend_q) begin
            gen_d = sum;
            bstart_d = sum;
            acnt_d = 24'h000001;
            bcnt_d = bcnt_q + 24'h000001;
            state_d = ST_RUN;
          end else if (~block_hold) begin
            // postponed restart handed to start delay
            pend_d = 1'b0;
            state_d = ST_IDLE;
          end
        end
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      gen_q <= 24'h000000;
      bstart_q <= 24'h000000;
      acnt_q <= 24'h000000;
      bcnt_q <= 24'h000000;
      first_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gen_q <= gen_d;
      bstart_q <= bstart_d;
      acnt_q <= acnt_d;
      bcnt_q <= bcnt_d;
      first_q <= first_d;
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge hclk) begin
    if (go) begin
      s_bsize_q <= bsize_q;
      s_nblk_q <= (nblk_q == 24'h000000) ? 24'h000001 : nblk_q;
      s_binc_q <= binc_q;
      s_ainc_q <= ainc_q;
    end
  end

  // start delay counter and external edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_q <= 1'b1;
      dcnt_q <= 5'h00;
    end else begin
      ext_prev_q <= ext_launch_in_n;
      if (req & (sdly_q != 5'h00))
        dcnt_q <= sdly_q;
      else if (dcnt_q != 5'h00)
        dcnt_q <= dcnt_q - 5'h01;
    end
  end

  // busy window after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      busy_cnt_q <= 5'h00;
    else if (busy_cnt_q <= 5'(BUSY_CLKS))
      busy_cnt_q <= busy_cnt_q + 5'h01;
  end

  // ahb address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsel_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wsel_q <= addr_ph & hwrite & (haddr[31:8] == 24'h000000);
      waddr_q <= {haddr[7:2], 2'b00};
      if (addr_ph & ~hwrite)
        hrdata_q <= (haddr[31:8] != 24'h000000) ? 32'h00000000 : rdata_mux;
    end
  end

  // read selection
  always_comb begin
    rdata_mux = 32'h00000000;
    case (raddr)
      OFF_START: rdata_mux = {8'h00, start_q};
      OFF_BSIZE: rdata_mux = {8'h00, bsize_q};
      OFF_NBLK: rdata_mux = {8'h00, nblk_q};
      OFF_BINC: rdata_mux = {8'h00, binc_q};
      OFF_AINC: rdata_mux = {8'h00, ainc_q};
      OFF_MODE: rdata_mux = {26'h0000000, mode_q};
      OFF_SDLY: rdata_mux = {27'h0000000, sdly_q};
      OFF_STATUS: rdata_mux = {29'h0000000, busy, state_q == ST_HOLD, state_q != ST_IDLE};
      OFF_GADDR: rdata_mux = {8'h00, gen_q};
      default: rdata_mux = rmap_hit ? {26'h0000000, map_q[rmap_idx]} : 32'h00000000;
    endcase
  end

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_RST;
      sdly_q <= SDLY_RST;
      for (int i = 0; i < AW; i++)
        map_q[i] <= 6'(i);
    end else if (wr_en) begin
      if (waddr_q == OFF_MODE)
        mode_q <= hwdata[MODE_W-1:0];
      if (waddr_q == OFF_SDLY)
        sdly_q <= hwdata[SDLY_W-1:0];
      if (map_hit)
        map_q[map_idx] <= hwdata[MAP_W-1:0];
    end
  end

  // parameter registers, untouched by reset
  always_ff @(posedge hclk) begin
    if (wr_en & (waddr_q == OFF_START)) start_q <= hwdata[AW-1:0];
    if (wr_en & (waddr_q == OFF_BSIZE)) bsize_q <= hwdata[AW-1:0];
    if (wr_en & (waddr_q == OFF_NBLK)) nblk_q <= hwdata[AW-1:0];
    if (wr_en & (waddr_q == OFF_BINC)) binc_q <= hwdata[AW-1:0];
    if (wr_en & (waddr_q == OFF_AINC)) ainc_q <= hwdata[AW-1:0];
  end

  // crosspoint switch
  logic [AW-1:0] xbar;
  genvar g;
  generate
    for (g = 0; g < AW; g++) begin : g_xbar
      assign xbar[g] = (map_q[g] <= 6'(MAP_LAST)) ? gen_q[5'(map_q[g])] : 1'b0;
    end
  endgenerate

  // output stage and lower-half skew line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 12'h000;
      flg_q <= '0;
      sync_q <= 1'b0;
      for (int i = 0; i < 8; i++)
        skew_q[i] <= 13'h0000;
    end else begin
      hi_q <= xbar[AW-1:HW];
      flg_q <= '{first: first_q, blk_end: blk_end, seq_end: seq_end};
      sync_q <= wr_launch | auto_req;
      skew_q[0] <= {first_q, xbar[HW-1:0]};
      for (int i = 1; i < 8; i++)
        skew_q[i] <= skew_q[i-1];
    end
  end

  // pin drive
  assign addr_out = {hi_q, skew_q[skew][HW-1:0]};
  assign first_addr_valid_n = ~skew_q[skew][HW];
  assign block_end_n = ~flg_q.blk_end;
  assign seq_done_n = ~flg_q.seq_end;
  assign sync_launch_out_n = ~sync_q;
  assign busy_n = ~busy;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  seq_end_both_a: assert property (!seq_done_n |-> !block_end_n) else $error("done without block end");
  cont_done_a: assert property ($past(cont) && $past(cont, 2) |-> seq_done_n) else $error("done in continuous");
  first_addr_a: assert property (go && !dual |=> gen_q == $past(start_q)) else $error("bad first address");
  step_a: assert property (state_q == ST_RUN && !blk_end && !go && !dual |=> gen_q == $past(gen_q) + $past(s_ainc_q))
    else $error("bad address step");
  blk_next_a: assert property (blk_end && !seq_end && !block_hold && !go && !dual
    |=> gen_q == $past(bstart_q) + $past(s_binc_q)) else $error("bad block start");
  hold_pause_a: assert property (state_q == ST_HOLD && block_hold && !go |=> $stable(gen_q))
    else $error("moved during hold");
  oneshot_stop_a: assert property (seq_end && !restart && !go |=> state_q == ST_IDLE) else $error("no stop");
  ext_sync_a: assert property (ext_req && !wr_launch && !auto_req |=> sync_launch_out_n)
    else $error("sync from external start");
  busy_len_a: assert property ($rose(busy) |-> busy [*8]) else $error("busy too short");
  busy_wr_a: assert property (busy && wsel_q |=> $stable(mode_q) && $stable(sdly_q)) else $error("write while busy");
  delay_a: assert property (req && sdly_q == 5'h1F && dcnt_q == 5'h00 |=> !go ##30 go) else $error("bad start delay");
  valid_pulse_a: assert property (!first_addr_valid_n && !$past(go) |=> first_addr_valid_n)
    else $error("valid longer than a clock");

endmodule // addr_sequencer
`default_nettype wire

// ==== test/launch_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module launch_partner (
  // clock
  input wire logic hclk,
  // requests from the bench
  input wire logic fire,
  input wire logic hold_req,
  // pins toward the sequencer
  output logic ext_launch_in_n,
  output logic block_hold
);
  // idle levels at time zero
  initial begin
    ext_launch_in_n = 1'b1;
    block_hold = 1'b0;
  end
  // launch low for the one clock of fire, hold follows request
  // single clock low
  always @(posedge hclk) begin
    ext_launch_in_n <= ~fire;
    block_hold <= hold_req;
  end
endmodule // launch_partner
`default_nettype wire

// ==== test/block_address_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module block_address_sequencer_tb
  import seq_pkg::*;
;
  typedef struct packed {
    logic [23:0] st, bs, nb, bi, ai;
    logic [5:0] md;
    logic [7:0] n;
  } row_s;
  // start, bsize, blocks, binc, ainc, mode, samples
  localparam row_s ROWS [0:9] = '{
    '{24'h000100, 24'h4, 24'h1, 24'h0, 24'h1, 6'h00, 8'h04},
    '{24'h00FFFE, 24'h3, 24'h3, 24'h000100, 24'h2, 6'h00, 8'h09},
    '{24'h123FFE, 24'h4, 24'h2, 24'h001010, 24'h001001, 6'h04, 8'h08},
    '{24'h000010, 24'h4, 24'h2, 24'h20, 24'h1, 6'h18, 8'h05},
    '{24'h000000, 24'h8, 24'h2, 24'h40, 24'h3, 6'h38, 8'h09},
    '{24'h000000, 24'h2, 24'h1, 24'h10, 24'h1, 6'h02, 8'h08},
    '{24'h000200, 24'h3, 24'h1, 24'h10, 24'h1, 6'h03, 8'h08},
    '{24'h000050, 24'h2, 24'h2, 24'h4, 24'h1, 6'h01, 8'h08},
    '{24'h000000, 24'h2, 24'h2, 24'h10, 24'h1, 6'h00, 8'h00},
    '{24'h800003, 24'h1, 24'h1, 24'h0, 24'h0, 6'h00, 8'h00}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fire, hold_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ext_launch_in_n, block_hold, block_end_n, seq_done_n, fav_n, sync_n, busy_n;
  logic [AW-1:0] addr_out;
  int err_count, checks_done, cyc, busy_cnt, sync_cnt, lat, lat0, s0, c;
  addr_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_launch_in_n(ext_launch_in_n), .block_hold(block_hold),
    .addr_out(addr_out), .block_end_n(block_end_n), .seq_done_n(seq_done_n),
    .first_addr_valid_n(fav_n), .sync_launch_out_n(sync_n), .busy_n(busy_n));
  launch_partner i_partner (.hclk(hclk), .fire(fire), .hold_req(hold_req),
    .ext_launch_in_n(ext_launch_in_n), .block_hold(block_hold));
  // clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // pulse counters and hang guard
  always @(negedge hclk) begin
    if (hresetn && busy_n === 1'b0) busy_cnt++;
    if (sync_n === 1'b0) sync_cnt++;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one ahb-lite single transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  // wait for first-address-valid, count clocks taken
  task automatic wfv(output int n);
    n = 0;
    @(negedge hclk);
    while (fav_n !== 1'b0 && n < 100) begin
      n++;
      @(negedge hclk);
    end
  endtask
  // expected generator address k of a row
  function automatic logic [23:0] ea(row_s r, int k);
    int t, b, i;
    logic [11:0] l, h;
    logic [23:0] f;
    t = r.bs * r.nb;
    if (r.md[1:0] == 2'b01) k = k % t;
    b = k / r.bs;
    i = k % r.bs;
    f = r.st + b * r.bi + i * r.ai;
    l = r.st[11:0] + b * r.bi[11:0] + i * r.ai[11:0];
    h = r.st[23:12] + b * r.bi[23:12] + i * r.ai[23:12];
    return r.md[2] ? {h, l} : f;
  endfunction
  // expected pins: valid, block end, done, skewed address
  function automatic logic [26:0] epin(row_s r, int k);
    int t, j;
    logic [23:0] a, b;
    t = r.bs * r.nb;
    j = k + r.md[5:3];
    a = ea(r, k);
    b = ea(r, j);
    if (r.md[1:0] == 2'b01) begin
      k = k % t;
      j = j % t;
    end
    return {k != 0, (j % r.bs) != r.bs - 1, r.md[1] || j != t - 1, b[23:12], a[11:0]};
  endfunction
  task automatic cfg(row_s r);
    wr(OFF_START, 32'(r.st));
    wr(OFF_BSIZE, 32'(r.bs));
    wr(OFF_NBLK, 32'(r.nb));
    wr(OFF_BINC, 32'(r.bi));
    wr(OFF_AINC, 32'(r.ai));
    wr(OFF_MODE, 32'(r.md));
    wr(OFF_LAUNCH, 32'h00000000);
  endtask
  task automatic run(row_s r);
    cfg(r);
    wfv(lat);
    for (int k = 0; k < r.n; k++) begin
      cmp({5'h00, fav_n, block_end_n, seq_done_n, addr_out}, {5'h00, epin(r, k)});
      @(negedge hclk);
    end
    if (r.md == 6'h00) repeat (3) begin
      cmp({5'h00, fav_n, block_end_n, seq_done_n, addr_out}, {8'h07, ea(r, r.n - 1)});
      @(negedge hclk);
    end
  endtask
  initial begin
    {hsel, hwrite, fire, hold_req, hresetn} = '0;
    {haddr, hwdata, htrans, cyc, err_count, checks_done, busy_cnt, sync_cnt} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wr(OFF_MODE, 32'h0000003F);
    for (int i = 0; i < 24; i++) begin
      xfer(1'b0, OFF_MAP0 + 8'(4 * i), 32'h0, q);
      cmp(q, 32'(i));
    end
    xfer(1'b0, OFF_MODE, 32'h0, q);
    cmp(q, 32'h00000000);
    cmp(32'(busy_cnt), 32'd25);
    wr(8'h30, 32'hFFFFFFFF);
    xfer(1'b0, 8'h30, 32'h0, q);
    cmp(q, 32'h00000000);
    wr(OFF_SDLY, 32'hFFFFFFFF);
    xfer(1'b0, OFF_SDLY, 32'h0, q);
    cmp(q, 32'h0000001F);
    wr(OFF_SDLY, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      run(ROWS[i]);
      if (i == 0) lat0 = lat;
    end
    wr(OFF_MODE, 32'h00000000);
    repeat (20) @(posedge hclk);
    // longest start delay and software sync pulse
    wr(OFF_SDLY, 32'h0000001F);
    s0 = sync_cnt;
    run(ROWS[0]);
    cmp(32'(lat), 32'(lat0 + 31));
    cmp(32'(sync_cnt - s0), 32'h1);
    // external launch gives no sync pulse
    wr(OFF_SDLY, 32'h00000000);
    s0 = sync_cnt;
    @(posedge hclk);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    wfv(lat);
    cmp({8'h00, addr_out}, 32'h00000100);
    cmp(32'(sync_cnt - s0), 32'h0);
    // block hold pauses at the first block boundary
    hold_req <= 1'b1;
    cfg(ROWS[8]);
    wfv(lat);
    repeat (6) @(negedge hclk);
    cmp({8'h00, addr_out}, 32'h00000001);
    @(posedge hclk);
    hold_req <= 1'b0;
    c = 0;
    while (addr_out !== 24'h000010 && c < 8) begin
      c++;
      @(negedge hclk);
    end
    cmp({8'h00, addr_out}, 32'h00000010);
    // held restart waits for the hold to drop, zero blocks acts as one
    hold_req <= 1'b1;
    cfg(row_s'{24'h000300, 24'h2, 24'h0, 24'h10, 24'h1, 6'h01, 8'h00});
    wfv(lat);
    repeat (6) @(negedge hclk);
    cmp({5'h00, fav_n, block_end_n, seq_done_n, addr_out}, {8'h07, 24'h000301});
    s0 = sync_cnt;
    @(posedge hclk);
    hold_req <= 1'b0;
    wfv(lat);
    cmp({8'h00, addr_out}, 32'h00000300);
    cmp(32'(sync_cnt - s0), 32'h1);
    // crosspoint: top bit fanned out, out of range forced low
    wr(OFF_MAP0, 32'd23);
    wr(OFF_MAP0 + 8'h04, 32'd30);
    wr(OFF_MAP0 + 8'h08, 32'd0);
    cfg(ROWS[9]);
    wfv(lat);
    cmp({8'h00, addr_out}, 32'h00800005);
    // reset after the last run has ended restores identity map and a fresh busy window
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    busy_cnt = 0;
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    xfer(1'b0, OFF_MAP0, 32'h0, q);
    cmp(q, 32'h00000000);
    cmp(32'(busy_cnt), 32'd25);
    wrap_up();
  end
endmodule // block_address_sequencer_tb
`default_nettype wire
